// file: uart_host_fifo_pkg.sv
package uart_host_fifo_pkg;

   // ==========================================================
   // Register offsets on the host port
   localparam logic [2:0] OFF_DATA     = 3'h0;
   localparam logic [2:0] OFF_IRQ_EN   = 3'h1;
   localparam logic [2:0] OFF_FIFO_CTL = 3'h2;

   // ==========================================================
   // FIFO control field positions
   localparam int FCTL_EN_BIT    = 0;
   localparam int FCTL_RXCLR_BIT = 1;
   localparam int FCTL_TXCLR_BIT = 2;
   localparam int FCTL_DMA_BIT   = 3;
   localparam int FCTL_TRIG_LSB  = 6;

   // ==========================================================
   // Interrupt enable field positions
   localparam int IRQEN_RXD_BIT = 0;
   localparam int IRQEN_TXE_BIT = 1;
   localparam int IRQEN_LS_BIT  = 2;
   localparam int IRQEN_MS_BIT  = 3;
   localparam int IRQEN_W       = 4;

   // ==========================================================
   // Sizes, trigger levels, timing
   localparam int         FIFO_DEPTH    = 16;
   localparam logic [4:0] FIFO_DEPTH_C  = 5'h10;
   localparam logic [4:0] LEGACY_DEPTH  = 5'h01;
   localparam logic [4:0] TRIG_LVL_0    = 5'h01;
   localparam logic [4:0] TRIG_LVL_1    = 5'h04;
   localparam logic [4:0] TRIG_LVL_2    = 5'h08;
   localparam logic [4:0] TRIG_LVL_3    = 5'h0E;
   localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

   // ==========================================================
   // Reset values
   localparam logic [7:0]         DIV_RST   = 8'h00;
   localparam logic [IRQEN_W-1:0] IRQEN_RST = 4'h0;
   localparam logic [1:0]         TRIG_RST  = 2'h0;

   // ==========================================================
   // Bundles
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } host_req_s;

   typedef struct packed {
      logic       rx_data;
      logic       tx_empty;
      logic       line_status;
      logic       modem_status;
      logic       char_timeout;
   } irq_cause_s;

   typedef enum logic [1:0] {
      RXQ_IDLE = 2'b01,
      RXQ_REQ  = 2'b10
   } rxq_state_e;

endpackage : uart_host_fifo_pkg

// file: uart_host_fifo_irq_ctrl.sv
// Functional notes
// - Two 16-byte FIFOs, active only in FIFO mode
// - DMA select honoured only in FIFO mode
// - Divisor bit clear: data buffers, interrupt enables
// - Divisor bit set: divisor low/high bytes
// - FIFO mode: receive reads pop receive FIFO
// - FIFO mode: transmit writes push transmit FIFO
// - Disabled source gives no indication, no interrupt
// - Modem enable: interrupt on any delta bit
// - Line enable: interrupt on error bit change
// - Transmit enable: interrupt while transmitter empty
// - Receive enable: interrupt on data or timeout
// - Top control bits pick trigger 1/4/8/14
// - FIFO mode off forces non-DMA operation
// - DMA: receive request at trigger, drops when empty
// - DMA: transmit request while any slot free
// - Non-DMA: receive request while data present
// - Non-DMA: transmit request only when empty
// - Transmit clear bit flushes, self-clears
// - Receive clear bit flushes, self-clears
// - Enable bit selects mode; clearing empties FIFOs
// - Other control bits need enable bit set
// - Timeout after four idle character times
`timescale 1ns/1ps

module uart_host_fifo_irq_ctrl (
   // Clock and reset
   input  wire logic                          ref_clk_in,
   input  wire logic                          rst_b_in,
   // Host register port
   input  wire uart_host_fifo_pkg::host_req_s host_req_in,
   input  wire logic                          divisor_access_bit_in,
   output logic [7:0]                         rdata_out,
   // Status from neighbouring blocks
   input  wire logic [3:0]                    line_status_err_in,
   input  wire logic                          line_status_read_in,
   input  wire logic [3:0]                    modem_status_delta_in,
   // Datapump receive side
   input  wire logic                          rx_push_valid_in,
   input  wire logic [7:0]                    rx_push_data_in,
   output logic                               rx_push_ready_out,
   input  wire logic                          char_tick_in,
   // Datapump transmit side
   output logic                               tx_valid_out,
   output logic [7:0]                         tx_data_out,
   input  wire logic                          tx_ready_in,
   // Host side outputs
   output logic                               host_irq_out,
   output uart_host_fifo_pkg::irq_cause_s     irq_pending_out,
   output logic                               fifo_mode_out,
   output logic                               rx_dma_request_out,
   output logic                               tx_dma_request_out,
   output logic [7:0]                         baud_divisor_low_out,
   output logic [7:0]                         baud_divisor_high_out
);
   import uart_host_fifo_pkg::*;
   // ==========================================================
   // Helpers
   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      case (sel)
         2'h0:    trig_level = TRIG_LVL_0;
         2'h1:    trig_level = TRIG_LVL_1;
         2'h2:    trig_level = TRIG_LVL_2;
         default: trig_level = TRIG_LVL_3;
      endcase
   endfunction : trig_level

   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = 4'(p + 4'h1);
   endfunction : ptr_inc

   // ==========================================================
   // State
   logic [7:0]       rx_mem_r [FIFO_DEPTH];
   logic [7:0]       tx_mem_r [FIFO_DEPTH];
   logic [3:0]       rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
   logic [4:0]       rx_cnt_r, tx_cnt_r;
   logic             fifo_en_r, dma_sel_r;
   logic [1:0]       trig_sel_r;
   logic [IRQEN_W-1:0] irq_enable_r;
   logic [7:0]       baud_divisor_low_r, baud_divisor_high_r;
   logic [7:0]       rdata_r, rdata_nxt;
   logic [3:0]       ls_prev_r;
   logic             ls_evt_r, ls_evt_nxt;
   logic [2:0]       idle_chars_r, idle_chars_nxt;
   logic             timeout_r, timeout_nxt;
   rxq_state_e       rxq_r, rxq_nxt;

   // ==========================================================
   // Host access decode
   wire logic hit_data  = host_req_in.addr == OFF_DATA;
   wire logic hit_irqen = host_req_in.addr == OFF_IRQ_EN;
   wire logic hit_fctl  = host_req_in.addr == OFF_FIFO_CTL;
   wire logic div_sel   = divisor_access_bit_in;
   wire logic [7:0] wd  = host_req_in.wdata;
   wire logic wr_tx     = host_req_in.wr && hit_data && !div_sel;
   wire logic rd_rx     = host_req_in.rd && hit_data && !div_sel;
   wire logic wr_irqen  = host_req_in.wr && hit_irqen && !div_sel;
   wire logic wr_div_lo = host_req_in.wr && hit_data && div_sel;
   wire logic wr_div_hi = host_req_in.wr && hit_irqen && div_sel;
   wire logic wr_fctl   = host_req_in.wr && hit_fctl;

   // ==========================================================
   // FIFO control decode
   // enable bit gates others
   wire logic fctl_on  = wr_fctl && wd[FCTL_EN_BIT];
   wire logic fctl_off = wr_fctl && !wd[FCTL_EN_BIT];
   wire logic rx_flush = fctl_off || (fctl_on && wd[FCTL_RXCLR_BIT]);
   wire logic tx_flush = fctl_off || (fctl_on && wd[FCTL_TXCLR_BIT]);
   wire logic dma_act  = fifo_en_r && dma_sel_r;
   wire logic [4:0] trig = trig_level(trig_sel_r);

   // ==========================================================
   // Capacity and occupancy
   // one byte in legacy mode
   wire logic [4:0] cap = fifo_en_r ? FIFO_DEPTH_C : LEGACY_DEPTH;
   wire logic rx_empty = rx_cnt_r == 5'h00;
   wire logic tx_empty = tx_cnt_r == 5'h00;
   wire logic rx_full  = rx_cnt_r >= cap;
   wire logic tx_full  = tx_cnt_r >= cap;

   wire logic rx_pop   = rd_rx && !rx_empty && !rx_flush;
   wire logic rx_push  = rx_push_valid_in && !rx_full && !rx_flush;
   wire logic tx_push  = wr_tx && !tx_full && !tx_flush;
   wire logic tx_pop   = tx_ready_in && !tx_empty && !tx_flush;

   // ==========================================================
   // Receive store
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_wp_r  <= 4'h0;
         rx_rp_r  <= 4'h0;
         rx_cnt_r <= 5'h00;
      end else if (rx_flush) begin
         rx_wp_r  <= 4'h0;
         rx_rp_r  <= 4'h0;
         rx_cnt_r <= 5'h00;
      end else begin
         if (rx_push) rx_wp_r <= ptr_inc(rx_wp_r);
         if (rx_pop) rx_rp_r <= ptr_inc(rx_rp_r);
         rx_cnt_r <= 5'(rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop});
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rx_push) rx_mem_r[rx_wp_r] <= rx_push_data_in;
      if (tx_push) tx_mem_r[tx_wp_r] <= wd;
   end

   // ==========================================================
   // Transmit store
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_wp_r  <= 4'h0;
         tx_rp_r  <= 4'h0;
         tx_cnt_r <= 5'h00;
      end else if (tx_flush) begin
         tx_wp_r  <= 4'h0;
         tx_rp_r  <= 4'h0;
         tx_cnt_r <= 5'h00;
      end else begin
         if (tx_push) tx_wp_r <= ptr_inc(tx_wp_r);
         if (tx_pop) tx_rp_r <= ptr_inc(tx_rp_r);
         tx_cnt_r <= 5'(tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop});
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fifo_en_r           <= 1'b0;
         dma_sel_r           <= 1'b0;
         trig_sel_r          <= TRIG_RST;
         irq_enable_r        <= IRQEN_RST;
         baud_divisor_low_r  <= DIV_RST;
         baud_divisor_high_r <= DIV_RST;
      end else begin
         if (wr_fctl) fifo_en_r <= wd[FCTL_EN_BIT];
         if (fctl_on) begin
            dma_sel_r  <= wd[FCTL_DMA_BIT];
            trig_sel_r <= wd[FCTL_TRIG_LSB +: 2];
         end
         if (wr_irqen) irq_enable_r <= wd[IRQEN_W-1:0];
         if (wr_div_lo) baud_divisor_low_r <= wd;
         if (wr_div_hi) baud_divisor_high_r <= wd;
      end
   end

   // ==========================================================
   // Read data
   always_comb begin
      rdata_nxt = rdata_r;
      if (host_req_in.rd) begin
         rdata_nxt = 8'h00;
         if (hit_data && div_sel) rdata_nxt = baud_divisor_low_r;
         else if (hit_data) rdata_nxt = rx_mem_r[rx_rp_r];
         else if (hit_irqen && div_sel) rdata_nxt = baud_divisor_high_r;
         else if (hit_irqen) rdata_nxt = {4'h0, irq_enable_r};
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) rdata_r <= 8'h00;
      else rdata_r <= rdata_nxt;
   end

   // ==========================================================
   // Line status change tracking
   // change of error bits
   wire logic ls_change = ls_prev_r != line_status_err_in;
   assign ls_evt_nxt = ls_change || (ls_evt_r && !line_status_read_in);

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ls_prev_r <= 4'h0;
         ls_evt_r  <= 1'b0;
      end else begin
         ls_prev_r <= line_status_err_in;
         ls_evt_r  <= ls_evt_nxt;
      end
   end

   // ==========================================================
   // Character timeout
   // four idle character times
   wire logic rx_move = rx_push || rx_pop || rx_flush;
   always_comb begin
      idle_chars_nxt = idle_chars_r;
      timeout_nxt    = timeout_r;
      if (rx_move || rx_empty || !fifo_en_r) begin
         idle_chars_nxt = 3'h0;
         timeout_nxt    = 1'b0;
      end else if (char_tick_in && idle_chars_r != TIMEOUT_CHARS) begin
         idle_chars_nxt = 3'(idle_chars_r + 3'h1);
         timeout_nxt    = 3'(idle_chars_r + 3'h1) == TIMEOUT_CHARS;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         idle_chars_r <= 3'h0;
         timeout_r    <= 1'b0;
      end else begin
         idle_chars_r <= idle_chars_nxt;
         timeout_r    <= timeout_nxt;
      end
   end

   // ==========================================================
   // Interrupt sources
   irq_cause_s cause;
   assign cause.rx_data      = !rx_empty && irq_enable_r[IRQEN_RXD_BIT];
   assign cause.char_timeout = timeout_r && irq_enable_r[IRQEN_RXD_BIT];
   assign cause.tx_empty     = tx_empty && irq_enable_r[IRQEN_TXE_BIT];
   assign cause.line_status  = ls_evt_r && irq_enable_r[IRQEN_LS_BIT];
   assign cause.modem_status = |modem_status_delta_in
                               && irq_enable_r[IRQEN_MS_BIT];
   assign irq_pending_out = cause;
   assign host_irq_out    = |cause;

   // ==========================================================
   // Receive request state
   wire logic rx_at_trig = rx_cnt_r >= trig;
   always_comb begin
      case (rxq_r)
         RXQ_IDLE: rxq_nxt = (rx_at_trig || timeout_r) ? RXQ_REQ
                                                       : RXQ_IDLE;
         RXQ_REQ:  rxq_nxt = rx_empty ? RXQ_IDLE : RXQ_REQ;
         default:  rxq_nxt = RXQ_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) rxq_r <= RXQ_IDLE;
      else rxq_r <= rxq_nxt;
   end

   // ==========================================================
   // Request outputs
   // receive request by mode
   wire logic rx_dma_lvl = !rx_empty
                           && (rxq_r == RXQ_REQ || rx_at_trig || timeout_r);
   assign rx_dma_request_out = dma_act ? rx_dma_lvl : !rx_empty;
   assign tx_dma_request_out = dma_act ? !tx_full : tx_empty;

   assign rdata_out             = rdata_r;
   assign rx_push_ready_out     = !rx_full;
   assign tx_valid_out          = !tx_empty;
   assign tx_data_out           = tx_mem_r[tx_rp_r];
   assign fifo_mode_out         = fifo_en_r;
   assign baud_divisor_low_out  = baud_divisor_low_r;
   assign baud_divisor_high_out = baud_divisor_high_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_fctl_write_off;
      wr_fctl && !wd[FCTL_EN_BIT];
   endsequence
   sequence s_stores_empty;
      rx_cnt_r == 5'h00 && tx_cnt_r == 5'h00 && !fifo_en_r;
   endsequence
   property p_mode_off_flush;
      s_fctl_write_off |=> s_stores_empty;
   endproperty
   a_mode_off_flush: assert property (p_mode_off_flush)
      else $error("mode off did not empty stores");

   property p_rx_clear;
      fctl_on && wd[FCTL_RXCLR_BIT] |=> rx_cnt_r == 5'h00;
   endproperty
   a_rx_clear: assert property (p_rx_clear)
      else $error("receive clear left data");

   property p_tx_clear;
      fctl_on && wd[FCTL_TXCLR_BIT] |=> tx_cnt_r == 5'h00 && !tx_valid_out;
   endproperty
   a_tx_clear: assert property (p_tx_clear)
      else $error("transmit clear left data");

   property p_div_low;
      wr_div_lo |=> baud_divisor_low_out == $past(host_req_in.wdata);
   endproperty
   a_div_low: assert property (p_div_low)
      else $error("divisor low byte not stored");

   property p_full_drop;
      wr_tx && tx_full && !tx_ready_in && !tx_flush
         |=> $stable(tx_cnt_r) && $stable(tx_wp_r);
   endproperty
   a_full_drop: assert property (p_full_drop)
      else $error("write to full transmit store accepted");

   property p_legacy_depth;
      !fifo_en_r |-> rx_cnt_r <= LEGACY_DEPTH && tx_cnt_r <= LEGACY_DEPTH;
   endproperty
   a_legacy_depth: assert property (p_legacy_depth)
      else $error("legacy mode holds more than one byte");

   property p_irq_masked;
      irq_enable_r == IRQEN_RST |-> !host_irq_out;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt with all sources disabled");

   property p_tx_irq;
      irq_enable_r[IRQEN_TXE_BIT] && tx_empty |-> host_irq_out;
   endproperty
   a_tx_irq: assert property (p_tx_irq)
      else $error("transmit empty interrupt missing");

   property p_nodma_tx;
      fifo_en_r && !dma_sel_r
         |-> tx_dma_request_out == (tx_cnt_r == 5'h00);
   endproperty
   a_nodma_tx: assert property (p_nodma_tx)
      else $error("non-DMA transmit request wrong");

   property p_dma_rx;
      dma_act && rx_cnt_r >= trig |=> rx_dma_request_out || rx_empty
                                      || !dma_act;
   endproperty
   a_dma_rx: assert property (p_dma_rx)
      else $error("DMA receive request late");

   property p_legacy_nodma;
      !fifo_en_r |-> tx_dma_request_out == tx_empty;
   endproperty
   a_legacy_nodma: assert property (p_legacy_nodma)
      else $error("DMA behaviour outside FIFO mode");

   property p_timeout_data;
      timeout_r |-> !rx_empty && fifo_en_r;
   endproperty
   a_timeout_data: assert property (p_timeout_data)
      else $error("timeout with empty receive store");
endmodule : uart_host_fifo_irq_ctrl

// file: dpump_model.sv
`timescale 1ns/1ps

module dpump_model (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   // Receive push
   output logic            rx_push_valid_out,
   output logic [7:0]      rx_push_data_out,
   input  wire logic       rx_push_ready_in,
   // Transmit sink
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       stall_in,
   output logic            tx_ready_out
);
   logic [7:0] got [$];

   initial begin
      rx_push_valid_out = 1'b0;
      rx_push_data_out  = 8'hA5;
   end

   // ==========================================================
   // Sink that stalls while asked to
   assign tx_ready_out = ~stall_in;

   always @(posedge ref_clk_in) begin
      if (rst_b_in && tx_valid_in && tx_ready_out) begin
         got.push_back(tx_data_in);
      end
   end

   // ==========================================================
   // One byte offered for one edge; released data is inverted
   task automatic push(input logic [7:0] b, output logic ok);
      @(negedge ref_clk_in);
      rx_push_valid_out = 1'b1;
      rx_push_data_out  = b;
      ok = rx_push_ready_in;
      @(negedge ref_clk_in);
      rx_push_valid_out = 1'b0;
      rx_push_data_out  = ~b;
   endtask : push
endmodule : dpump_model

// file: tb.sv
`timescale 1ns/1ps

module tb;
   import uart_host_fifo_pkg::*;

   // ==========================================================
   // Signals
   logic       ref_clk_in = 1'b0;
   logic       rst_b_in   = 1'b0;
   host_req_s  req        = '0;
   logic       div_sel    = 1'b0;
   logic [3:0] ls_err     = 4'h0;
   logic       ls_rd      = 1'b0;
   logic [3:0] ms_dlt     = 4'h0;
   logic       tick       = 1'b0;
   logic       stall      = 1'b1;
   logic       pv, pr, tv, tr, irq, fmode, rxdr, txdr, ok;
   logic [7:0] pd, td, rdata, dl, dh, q, v;
   irq_cause_s pend;
   logic [7:0] dv [2];
   logic [7:0] exp_q [$];
   int         n_errors    = 0;
   int         checks_done = 0;

   always #10 ref_clk_in = ~ref_clk_in;

   uart_host_fifo_irq_ctrl dut (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .host_req_in(req), .divisor_access_bit_in(div_sel),
      .rdata_out(rdata), .line_status_err_in(ls_err),
      .line_status_read_in(ls_rd), .modem_status_delta_in(ms_dlt),
      .rx_push_valid_in(pv), .rx_push_data_in(pd),
      .rx_push_ready_out(pr), .char_tick_in(tick),
      .tx_valid_out(tv), .tx_data_out(td), .tx_ready_in(tr),
      .host_irq_out(irq), .irq_pending_out(pend),
      .fifo_mode_out(fmode), .rx_dma_request_out(rxdr),
      .tx_dma_request_out(txdr), .baud_divisor_low_out(dl),
      .baud_divisor_high_out(dh)
   );

   dpump_model dp (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .rx_push_valid_out(pv), .rx_push_data_out(pd),
      .rx_push_ready_in(pr), .tx_valid_in(tv), .tx_data_in(td),
      .stall_in(stall), .tx_ready_out(tr)
   );

   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t byte %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkb(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
      end
   endtask : chkb

   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task automatic acc(input logic [2:0] a, input logic [7:0] d,
                      input logic w);
      @(negedge ref_clk_in);
      req = '{addr: a, wdata: d, wr: w, rd: ~w};
      @(negedge ref_clk_in);
      req = '0;
      q = rdata;
   endtask : acc

   task automatic pulse(ref logic s);
      @(negedge ref_clk_in);
      s = 1'b1;
      @(negedge ref_clk_in);
      s = 1'b0;
   endtask : pulse

   function automatic int lvl(input int t);
      return (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
   endfunction : lvl

   // Raise or remove one interrupt source
   task automatic cause(input int s, input logic on);
      case (s)
         0: begin
            if (on) dp.push(8'($urandom), ok);
            else acc(OFF_DATA, 8'h00, 1'b0);
         end
         1: begin
            if (!on) acc(OFF_DATA, 8'h3C, 1'b1);
         end
         2: begin
            if (on) ls_err = ls_err ^ 4'(1 << ($urandom % 4));
            else pulse(ls_rd);
         end
         default: begin
            ms_dlt = on ? 4'(1 << ($urandom % 4)) : 4'h0;
         end
      endcase
      @(negedge ref_clk_in);
   endtask : cause

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h90607447));
      repeat (2) @(negedge ref_clk_in);
      rst_b_in = 1'b1;
      chkb(txdr, 1'b1);
      chkb(rxdr, 1'b0);
      chkb(fmode, 1'b0);
      div_sel = 1'b1;
      for (int i = 0; i < 2; i++) begin
         dv[i] = 8'($urandom);
         acc(3'(i), dv[i], 1'b1);
         acc(3'(i), 8'h00, 1'b0);
         chk(q, dv[i]);
      end
      chk(dl, dv[0]);
      chk(dh, dv[1]);
      div_sel = 1'b0;
      acc(OFF_IRQ_EN, 8'hF5, 1'b1);
      acc(OFF_IRQ_EN, 8'h00, 1'b0);
      chk(q, 8'h05);
      chk(dl, dv[0]);
      chkb(irq, 1'b0);
      for (int s = 0; s < 4; s++) begin
         acc(OFF_IRQ_EN, 8'h00, 1'b1);
         cause(s, 1'b1);
         chkb(irq, 1'b0);
         acc(OFF_IRQ_EN, 8'(1 << s), 1'b1);
         if (s == 2) cause(s, 1'b1);
         chkb(irq, 1'b1);
         cause(s, 1'b0);
         chkb(irq, 1'b0);
      end
      acc(OFF_FIFO_CTL, 8'h05, 1'b1);
      chkb(fmode, 1'b1);
      chkb(tv, 1'b0);
      for (int i = 0; i < 17; i++) begin
         v = 8'($urandom);
         dp.push(v, ok);
         chkb(ok, i < 16);
         if (i < 16) exp_q.push_back(v);
      end
      chkb(rxdr, 1'b1);
      acc(OFF_IRQ_EN, 8'h01, 1'b1);
      repeat (3) pulse(tick);
      @(negedge ref_clk_in);
      chkb(pend.char_timeout, 1'b0);
      pulse(tick);
      @(negedge ref_clk_in);
      chkb(pend.char_timeout, 1'b1);
      for (int i = 0; i < 16; i++) begin
         acc(OFF_DATA, 8'h00, 1'b0);
         chk(q, exp_q.pop_front());
      end
      chkb(rxdr, 1'b0);
      chkb(pend.char_timeout, 1'b0);
      for (int i = 0; i < 17; i++) begin
         v = 8'($urandom);
         acc(OFF_DATA, v, 1'b1);
         if (i < 16) exp_q.push_back(v);
         if (i == 0) begin
            chkb(txdr, 1'b0);
            acc(OFF_FIFO_CTL, 8'h09, 1'b1);
         end
         chkb(txdr, i < 15);
      end
      stall = 1'b0;
      for (int k = 0; k < 60 && dp.got.size() < 17; k++) begin
         @(negedge ref_clk_in);
      end
      chk(8'(dp.got.size()), 8'h10);
      for (int i = 0; i < 16 && i < dp.got.size(); i++) begin
         chk(dp.got[i], exp_q[i]);
      end
      stall = 1'b1;
      for (int t = 0; t < 4; t++) begin
         acc(OFF_FIFO_CTL, {2'(t), 6'h0B}, 1'b1);
         chkb(rxdr, 1'b0);
         for (int k = 1; k <= lvl(t); k++) begin
            dp.push(8'($urandom), ok);
            chkb(rxdr, k >= lvl(t));
         end
      end
      for (int k = 0; k < 14; k++) begin
         acc(OFF_DATA, 8'h00, 1'b0);
         chkb(rxdr, k < 13);
      end
      acc(OFF_DATA, 8'h77, 1'b1);
      acc(OFF_FIFO_CTL, 8'hCD, 1'b1);
      chkb(tv, 1'b0);
      acc(OFF_FIFO_CTL, 8'hC8, 1'b1);
      chkb(fmode, 1'b0);
      v = 8'($urandom);
      dp.push(v, ok);
      chkb(rxdr, 1'b1);
      dp.push(~v, ok);
      chkb(ok, 1'b0);
      acc(OFF_DATA, 8'h00, 1'b0);
      chk(q, v);
      close_out();
   end
endmodule : tb
